//--- rtl/bl_regs_map.svh
`ifndef BL_REGS_MAP_SVH
`define BL_REGS_MAP_SVH

// byte addresses of the register bank
`define BL_ADDR_BIAS_CONFIG      8'h80
`define BL_ADDR_TABLE_ROW        8'h81
`define BL_ADDR_RESERVED_A       8'h82
`define BL_ADDR_DAC_DIRECT       8'h83
`define BL_ADDR_RESERVED_B       8'h84
`define BL_ADDR_OUTPUT_SOURCE    8'h85
`define BL_ADDR_WRITE_UNLOCK     8'h86
`define BL_ADDR_THERMOMETER      8'h87
`define BL_ADDR_RSVD_BLOCK_LO    8'h88
`define BL_ADDR_RSVD_BLOCK_HI    8'h8f
`define BL_ADDR_TABLE_BASE       8'h90
`define BL_ADDR_TABLE_LAST       8'hcf

// bias_config fields
`define BL_BIT_ADC_SETTLE_BYPASS 7
`define BL_BIT_DIRECT_PERSIST    6
`define BL_BIT_CURRENT_POLARITY  5
`define BL_MASK_BIAS_CONFIG      8'he0

// table_row_override field
`define BL_MASK_TABLE_ROW        8'h3f

// output_source_config fields
`define BL_BIT_DAC_OVERRIDE      5
`define BL_BIT_TABLE_OVERRIDE    4
`define BL_LSB_FULL_SCALE        0
`define BL_MASK_OUTPUT_SOURCE    8'h33

// write unlock codes
`define BL_UNLOCK_SET            8'h80
`define BL_UNLOCK_CLEAR          8'h00
`define BL_UNLOCK_BIT            7

// factory and power-up values
`define BL_FACTORY_BIAS_CONFIG   8'h00
`define BL_FACTORY_TABLE_ROW     8'h00
`define BL_FACTORY_DAC_DIRECT    8'h00
`define BL_FACTORY_OUTPUT_SOURCE 8'h03
`define BL_FACTORY_TABLE_BYTE    8'h00
`define BL_RESET_WRITE_UNLOCK    8'h00
`define BL_RESET_THERMOMETER     8'h00
`define BL_RESET_DAC_WORD        8'h00
`define BL_READ_UNMAPPED         8'h00

// thermometer filter: agreeing conversions needed
`define BL_SETTLE_AGREE          2'h3

// nonvolatile write cycle time
`define BL_NV_WRITE_TIME_MS      10
`define BL_CLK_PERIOD_NS         100
`define BL_NV_WRITE_CYCLES \
  ((`BL_NV_WRITE_TIME_MS * 1000000) / `BL_CLK_PERIOD_NS)

`endif

//--- rtl/bl_pkg.sv
`default_nettype none
package bl_pkg;

  // one decoded byte operation of the 2-wire slave front end
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       stop;
    logic [7:0] addr;
    logic [7:0] data;
  } bl_bus_req_t;

  typedef struct packed {
    logic       ack;
    logic       nack;
    logic [7:0] rdata;
  } bl_bus_rsp_t;

  typedef struct packed {
    logic       sink;
    logic [1:0] full_scale;
    logic [7:0] dac_word;
  } bl_analog_ctl_t;

  typedef enum logic [2:0] {
    BL_LOAD   = 3'b001,
    BL_RUN    = 3'b010,
    BL_NVBUSY = 3'b100
  } bl_state_t;

endpackage
`default_nettype wire

//--- rtl/bl_settle_filter.sv
`include "bl_regs_map.svh"
`default_nettype none
module bl_settle_filter (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_conv_valid,
  input  wire logic [7:0] i_conv_code,
  input  wire logic       i_bypass,
  output logic      [7:0] o_reading,
  output logic            o_reading_valid
);

  logic [7:0] last_reg,  last_next;
  logic [1:0] agree_reg, agree_next;
  logic [7:0] read_reg,  read_next;
  logic       valid_reg, valid_next;
  logic       valid_last_reg, valid_last_next;

  always_comb begin
    last_next  = last_reg;
    agree_next = agree_reg;
    read_next  = read_reg;
    valid_next = valid_reg;
    if (i_conv_valid) begin
      last_next = i_conv_code;
      if (i_conv_code[7:2] == last_reg[7:2] && valid_last_reg) begin
        if (agree_reg != `BL_SETTLE_AGREE) begin
          agree_next = agree_reg + 2'h1;
        end
      end else begin
        agree_next = 2'h0;
      end
      // every conversion, or four in a row agreeing in the upper six bits
      if (i_bypass || agree_next == `BL_SETTLE_AGREE) begin
        read_next  = i_conv_code;
        valid_next = 1'b1;
      end
    end
  end

  always_comb begin
    valid_last_next = valid_last_reg | i_conv_valid;
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      last_reg       <= `BL_RESET_THERMOMETER;
      agree_reg      <= 2'h0;
      read_reg       <= `BL_RESET_THERMOMETER;
      valid_reg      <= 1'b0;
      valid_last_reg <= 1'b0;
    end else begin
      last_reg       <= last_next;
      agree_reg      <= agree_next;
      read_reg       <= read_next;
      valid_reg      <= valid_next;
      valid_last_reg <= valid_last_next;
    end
  end

  assign o_reading       = read_reg;
  assign o_reading_valid = valid_reg;

endmodule
`default_nettype wire

//--- rtl/bl_register_bank.sv
`include "bl_regs_map.svh"
`default_nettype none
module bl_register_bank #(
  parameter int unsigned NV_WRITE_CYCLES = `BL_NV_WRITE_CYCLES,
  parameter int unsigned TABLE_ROWS      = 64
) (
  input  wire logic               i_sys_clk,
  input  wire logic               i_rstn,
  input  wire bl_pkg::bl_bus_req_t i_bus_req,
  input  wire logic               i_adc_valid,
  input  wire logic [7:0]         i_adc_code,
  output logic                    o_addr_ack_ok,
  output bl_pkg::bl_bus_rsp_t     o_bus_rsp,
  output bl_pkg::bl_analog_ctl_t  o_analog,
  output logic [7:0]              o_row_addr
);

  localparam int unsigned CW = $clog2(NV_WRITE_CYCLES + 1);
  localparam logic [CW-1:0] NV_LAST = CW'(NV_WRITE_CYCLES - 1);

  // volatile working copies
  logic [7:0] cfg_reg,  cfg_next;
  logic [7:0] row_reg,  row_next;
  logic [7:0] dir_reg,  dir_next;
  logic [7:0] src_reg,  src_next;
  logic       unl_reg,  unl_next;
  // nonvolatile cells
  logic [7:0] nv_cfg_reg, nv_cfg_next;
  logic [7:0] nv_row_reg, nv_row_next;
  logic [7:0] nv_dir_reg, nv_dir_next;
  logic [7:0] nv_src_reg, nv_src_next;
  logic       dirty_reg,  dirty_next;
  logic [CW-1:0]     cnt_reg, cnt_next;
  bl_pkg::bl_state_t st_reg,  st_next;
  bl_pkg::bl_bus_rsp_t rsp_reg, rsp_next;

  logic [7:0] table_mem [TABLE_ROWS];
  logic [5:0] tbl_idx;
  logic       tbl_hit;
  logic       tbl_wr;
  logic [7:0] reading;
  logic       reading_valid;

  bl_settle_filter u_filter (
    .i_sys_clk      (i_sys_clk),
    .i_rstn         (i_rstn),
    .i_conv_valid   (i_adc_valid),
    .i_conv_code    (i_adc_code),
    .i_bypass       (cfg_reg[`BL_BIT_ADC_SETTLE_BYPASS]),
    .o_reading      (reading),
    .o_reading_valid(reading_valid)
  );

  // table window decode
  always_comb begin
    tbl_hit = (i_bus_req.addr >= `BL_ADDR_TABLE_BASE) &&
              (i_bus_req.addr <= `BL_ADDR_TABLE_LAST);
    // outside the window the index is computed but never used
    tbl_idx = 6'(i_bus_req.addr - `BL_ADDR_TABLE_BASE);
  end

  // register access, unlock, nonvolatile cycle
  always_comb begin
    logic accept;
    accept      = 1'b0;
    cfg_next    = cfg_reg;
    row_next    = row_reg;
    dir_next    = dir_reg;
    src_next    = src_reg;
    unl_next    = unl_reg;
    nv_cfg_next = nv_cfg_reg;
    nv_row_next = nv_row_reg;
    nv_dir_next = nv_dir_reg;
    nv_src_next = nv_src_reg;
    dirty_next  = dirty_reg;
    cnt_next    = cnt_reg;
    st_next     = st_reg;
    tbl_wr      = 1'b0;
    rsp_next    = '0;
    rsp_next.rdata = rsp_reg.rdata;
    case (st_reg)
      bl_pkg::BL_LOAD: begin
        // recall the nonvolatile copies once after power-up
        cfg_next = nv_cfg_reg;
        row_next = nv_row_reg;
        dir_next = nv_dir_reg;
        src_next = nv_src_reg;
        st_next  = bl_pkg::BL_RUN;
        rsp_next.nack = i_bus_req.wr | i_bus_req.rd;
      end
      bl_pkg::BL_RUN: begin
        if (i_bus_req.rd) begin
          rsp_next.ack = 1'b1;
          case (i_bus_req.addr)
            `BL_ADDR_BIAS_CONFIG:   rsp_next.rdata = cfg_reg;
            `BL_ADDR_TABLE_ROW:     rsp_next.rdata = row_reg;
            `BL_ADDR_DAC_DIRECT:    rsp_next.rdata = dir_reg;
            `BL_ADDR_OUTPUT_SOURCE: rsp_next.rdata = src_reg;
            `BL_ADDR_WRITE_UNLOCK:
              rsp_next.rdata = {unl_reg, 7'h00};
            `BL_ADDR_THERMOMETER:   rsp_next.rdata = reading;
            default: begin
              // reserved addresses read as zero
              rsp_next.rdata = tbl_hit ? table_mem[tbl_idx]
                                       : `BL_READ_UNMAPPED;
            end
          endcase
        end else if (i_bus_req.wr) begin
          if (i_bus_req.addr == `BL_ADDR_WRITE_UNLOCK) begin
            accept = 1'b1;
            if (i_bus_req.data == `BL_UNLOCK_SET) begin
              unl_next = 1'b1;
            end else if (i_bus_req.data == `BL_UNLOCK_CLEAR) begin
              unl_next = 1'b0;
            end
            // any other unlock value is acknowledged and ignored
          end else if (unl_reg) begin
            accept = 1'b1;
            case (i_bus_req.addr)
              `BL_ADDR_BIAS_CONFIG: begin
                cfg_next    = i_bus_req.data & `BL_MASK_BIAS_CONFIG;
                nv_cfg_next = cfg_next;
                dirty_next  = 1'b1;
              end
              `BL_ADDR_TABLE_ROW: begin
                row_next = i_bus_req.data & `BL_MASK_TABLE_ROW;
                if (cfg_reg[`BL_BIT_DIRECT_PERSIST]) begin
                  nv_row_next = row_next;
                  dirty_next  = 1'b1;
                end
              end
              `BL_ADDR_DAC_DIRECT: begin
                dir_next = i_bus_req.data;
                if (cfg_reg[`BL_BIT_DIRECT_PERSIST]) begin
                  nv_dir_next = dir_next;
                  dirty_next  = 1'b1;
                end
              end
              `BL_ADDR_OUTPUT_SOURCE: begin
                src_next    = i_bus_req.data & `BL_MASK_OUTPUT_SOURCE;
                nv_src_next = src_next;
                dirty_next  = 1'b1;
              end
              default: begin
                if (tbl_hit) begin
                  tbl_wr     = 1'b1;
                  dirty_next = 1'b1;
                end
              end
            endcase
          end
          rsp_next.ack  = accept;
          rsp_next.nack = ~accept;
        end
        // a stop after nonvolatile changes starts the self-timed cycle;
        // unlock-only or volatile-only sequences start none
        if (i_bus_req.stop && dirty_next) begin
          dirty_next = 1'b0;
          cnt_next   = '0;
          st_next    = bl_pkg::BL_NVBUSY;
        end
      end
      bl_pkg::BL_NVBUSY: begin
        // every request is refused until the cycle ends
        rsp_next.nack = i_bus_req.wr | i_bus_req.rd;
        cnt_next      = cnt_reg + CW'(1);
        if (cnt_reg == NV_LAST) begin
          st_next = bl_pkg::BL_RUN;
        end
      end
      default: begin
        st_next = bl_pkg::BL_LOAD;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cfg_reg    <= `BL_FACTORY_BIAS_CONFIG;
      row_reg    <= `BL_FACTORY_TABLE_ROW;
      dir_reg    <= `BL_FACTORY_DAC_DIRECT;
      src_reg    <= `BL_FACTORY_OUTPUT_SOURCE;
      unl_reg    <= 1'b0;
      // reset models first power-up, so the cells load factory values as well
      nv_cfg_reg <= `BL_FACTORY_BIAS_CONFIG;
      nv_row_reg <= `BL_FACTORY_TABLE_ROW;
      nv_dir_reg <= `BL_FACTORY_DAC_DIRECT;
      nv_src_reg <= `BL_FACTORY_OUTPUT_SOURCE;
      dirty_reg  <= 1'b0;
      cnt_reg    <= '0;
      st_reg     <= bl_pkg::BL_LOAD;
      rsp_reg    <= '0;
    end else begin
      cfg_reg    <= cfg_next;
      row_reg    <= row_next;
      dir_reg    <= dir_next;
      src_reg    <= src_next;
      unl_reg    <= unl_next;
      nv_cfg_reg <= nv_cfg_next;
      nv_row_reg <= nv_row_next;
      nv_dir_reg <= nv_dir_next;
      nv_src_reg <= nv_src_next;
      dirty_reg  <= dirty_next;
      cnt_reg    <= cnt_next;
      st_reg     <= st_next;
      rsp_reg    <= rsp_next;
    end
  end

  // nonvolatile table bytes, one flop group per row
  for (genvar g = 0; g < TABLE_ROWS; g++) begin : g_table
    logic [7:0] byte_next;
    always_comb begin
      byte_next = table_mem[g];
      if (tbl_wr && tbl_idx == 6'(g)) begin
        byte_next = i_bus_req.data;
      end
    end
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        table_mem[g] <= `BL_FACTORY_TABLE_BYTE;
      end else begin
        table_mem[g] <= byte_next;
      end
    end
  end

  // DAC source selection
  bl_pkg::bl_analog_ctl_t ana_reg, ana_next;
  logic [7:0] row_addr_reg, row_addr_next;
  logic       ack_ok_reg, ack_ok_next;
  always_comb begin
    logic [5:0] row;
    row = 6'h00;
    if (src_reg[`BL_BIT_TABLE_OVERRIDE]) begin
      row = row_reg[5:0];
    end else begin
      row = reading[7:2];
    end
    row_addr_next = `BL_ADDR_TABLE_BASE + {2'h0, row};
    ana_next.sink = cfg_reg[`BL_BIT_CURRENT_POLARITY];
    ana_next.full_scale =
      src_reg[`BL_LSB_FULL_SCALE +: 2];
    // without a DAC or table override the DAC word stays 00h until the first filtered reading
    if (st_reg == bl_pkg::BL_LOAD) begin
      ana_next.dac_word = `BL_RESET_DAC_WORD;
    end else if (src_reg[`BL_BIT_DAC_OVERRIDE]) begin
      ana_next.dac_word = dir_reg;
    end else if (src_reg[`BL_BIT_TABLE_OVERRIDE]) begin
      ana_next.dac_word = table_mem[row];
    end else if (reading_valid) begin
      ana_next.dac_word = table_mem[row];
    end else begin
      ana_next.dac_word = `BL_RESET_DAC_WORD;
    end
    // looks at the next state so the flag rises together with
    // the return to normal operation
    ack_ok_next = (st_next == bl_pkg::BL_RUN);
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ana_reg      <= '0;
      row_addr_reg <= `BL_ADDR_TABLE_BASE;
      ack_ok_reg   <= 1'b0;
    end else begin
      ana_reg      <= ana_next;
      row_addr_reg <= row_addr_next;
      ack_ok_reg   <= ack_ok_next;
    end
  end

  assign o_bus_rsp     = rsp_reg;
  assign o_analog      = ana_reg;
  assign o_row_addr    = row_addr_reg;
  assign o_addr_ack_ok = ack_ok_reg;

endmodule
`default_nettype wire

//--- test/bl_register_bank_sva.sv
`default_nettype none
module bl_register_bank_sva #(
  parameter int unsigned NV_WRITE_CYCLES = 20,
  parameter int unsigned TABLE_ROWS      = 64
) (
  input wire logic                   i_sys_clk,
  input wire logic                   i_rstn,
  input wire bl_pkg::bl_bus_req_t    i_bus_req,
  input wire logic                   i_adc_valid,
  input wire logic [7:0]             i_adc_code,
  input wire logic                   o_addr_ack_ok,
  input wire bl_pkg::bl_bus_rsp_t    o_bus_rsp,
  input wire bl_pkg::bl_analog_ctl_t o_analog,
  input wire logic [7:0]             o_row_addr
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  logic        latch_reg, latch_next;
  int unsigned low_reg, low_next;
  logic        req;
  assign req = i_bus_req.wr || i_bus_req.rd;
  // shadow of the unlock latch and length of each not-ready stretch
  always_comb begin
    latch_next = latch_reg;
    low_next = o_addr_ack_ok ? 0 : low_reg + 1;
    if (i_bus_req.wr && i_bus_req.addr == 8'h86 && o_addr_ack_ok) begin
      if (i_bus_req.data == 8'h80)
        latch_next = 1'b1;
      else if (i_bus_req.data == 8'h00)
        latch_next = 1'b0;
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      latch_reg <= 1'b0;
      low_reg <= 0;
    end else begin
      latch_reg <= latch_next;
      low_reg <= low_next;
    end
  end
  AST_ANSWER: assert property (
    req |=> o_bus_rsp.ack != o_bus_rsp.nack)
    else $error("request without single answer");
  AST_QUIET: assert property (
    !req |=> !o_bus_rsp.ack && !o_bus_rsp.nack)
    else $error("answer without request");
  AST_LOCKED: assert property (
    i_bus_req.wr && i_bus_req.addr != 8'h86 && !latch_reg
    |=> o_bus_rsp.nack)
    else $error("locked write acked");
  AST_BUSY_NACK: assert property (
    req && !o_addr_ack_ok |=> o_bus_rsp.nack)
    else $error("request acked while busy");
  AST_NV_BOUND: assert property (
    low_reg <= NV_WRITE_CYCLES + 2)
    else $error("write cycle too long");
  AST_ROW_RANGE: assert property (
    o_row_addr inside {[8'h90:8'hcf]})
    else $error("row address outside table");
  AST_RSVD_READ: assert property (
    i_bus_req.rd && o_addr_ack_ok && i_bus_req.addr inside {[8'h88:8'h8f]}
    |=> o_bus_rsp.rdata == 8'h00)
    else $error("reserved read not zero");
  AST_RDATA_HOLD: assert property (
    !i_bus_req.rd |=> $stable(o_bus_rsp.rdata))
    else $error("read data moved without read");
  AST_UNLOCK_READ: assert property (
    i_bus_req.rd && o_addr_ack_ok && i_bus_req.addr == 8'h86
    |=> o_bus_rsp.rdata == {latch_reg, 7'h00})
    else $error("unlock read wrong");
  cover property (i_bus_req.wr && i_bus_req.addr == 8'h86);
  cover property ($fell(o_addr_ack_ok));
  cover property (i_adc_valid ##1 1'b1);
endmodule
bind bl_register_bank bl_register_bank_sva #(
  .NV_WRITE_CYCLES(NV_WRITE_CYCLES),
  .TABLE_ROWS     (TABLE_ROWS)
) u_sva (
  .i_sys_clk    (i_sys_clk),
  .i_rstn       (i_rstn),
  .i_bus_req    (i_bus_req),
  .i_adc_valid  (i_adc_valid),
  .i_adc_code   (i_adc_code),
  .o_addr_ack_ok(o_addr_ack_ok),
  .o_bus_rsp    (o_bus_rsp),
  .o_analog     (o_analog),
  .o_row_addr   (o_row_addr)
);
`default_nettype wire

//--- test/bl_bus_master_model.sv
`default_nettype none
module bl_bus_master_model (
  input  wire logic                i_sys_clk,
  input  wire bl_pkg::bl_bus_rsp_t i_rsp,
  output var  bl_pkg::bl_bus_req_t o_req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_req = '0;
  // one byte per call; callers keep reserved bits zero
  task automatic xfer(input logic wr, input logic [7:0] a, d,
                      output logic ack, output logic [7:0] rd);
    @(negedge i_sys_clk);
    o_req = {wr, !wr, 1'b0, a, d};
    @(negedge i_sys_clk);
    // the answer stands only in the cycle after the taking edge
    ack = i_rsp.ack;
    rd = i_rsp.rdata;
    // released fields show a changed pattern, not the last value
    o_req = {3'b000, ~a, ~d};
  endtask
  // ends a sequence; the host then polls readiness
  task automatic stop_seq();
    @(negedge i_sys_clk);
    o_req.stop = 1'b1;
    @(negedge i_sys_clk);
    o_req.stop = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- test/tb_bias_lut_register_bank.sv
`default_nettype none
module tb_bias_lut_register_bank;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NVW = 20;
  logic                   i_sys_clk, i_rstn, adc_valid, ack_ok, ack;
  logic [7:0]             adc_code, row_addr, rd, t, r, c, src;
  logic [7:0]             tbl [64];
  bl_pkg::bl_bus_req_t    req;
  bl_pkg::bl_bus_rsp_t    rsp;
  bl_pkg::bl_analog_ctl_t ana;
  int                     n_mismatch = 0, comparisons = 0;
  bl_register_bank #(.NV_WRITE_CYCLES(NVW), .TABLE_ROWS(64))
    u_bl_register_bank (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
    .i_bus_req(req), .i_adc_valid(adc_valid), .i_adc_code(adc_code),
    .o_addr_ack_ok(ack_ok), .o_bus_rsp(rsp), .o_analog(ana),
    .o_row_addr(row_addr));
  bl_bus_master_model u_bl_bus_master_model (.i_sys_clk(i_sys_clk),
    .i_rsp(rsp), .o_req(req));
  task automatic chk(input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d, input logic e);
    u_bl_bus_master_model.xfer(1'b1, a, d, ack, rd);
    chk({7'h00, ack}, {7'h00, e});
    @(negedge i_sys_clk);
  endtask
  task automatic rdc(input logic [7:0] a, e);
    u_bl_bus_master_model.xfer(1'b0, a, 8'h00, ack, rd);
    chk(rd, e);
  endtask
  task automatic adc(input logic [7:0] v);
    @(negedge i_sys_clk);
    adc_valid = 1'b1;
    adc_code = v;
    @(negedge i_sys_clk);
    adc_valid = 1'b0;
    adc_code = ~v;
    repeat (2) @(negedge i_sys_clk);
  endtask
  task automatic stop_wait(input logic nv);
    int k;
    u_bl_bus_master_model.stop_seq();
    repeat (2) @(negedge i_sys_clk);
    chk({7'h00, ack_ok}, {7'h00, !nv});
    if (nv) begin
      u_bl_bus_master_model.xfer(1'b0, 8'h80, 8'h00, ack, rd);
      chk({7'h00, ack}, 8'h00);
      for (k = 0; k < NVW + 4 && !ack_ok; k++) @(negedge i_sys_clk);
      chk({7'h00, ack_ok}, 8'h01);
    end
  endtask
  function automatic logic [7:0] dac_exp(input logic [7:0] s, w, d, g);
    if (s[5])
      return d;
    return s[4] ? tbl[w[5:0]] : tbl[g[7:2]];
  endfunction
  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    #2000000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    i_rstn = 1'b0;
    adc_valid = 1'b0;
    adc_code = 8'h00;
    void'($urandom(57953));
    repeat (16) @(negedge i_sys_clk);
    i_rstn = 1'b1;
    repeat (2) @(negedge i_sys_clk);
    chk({6'h00, ana.full_scale}, 8'h03);
    chk(row_addr, 8'h90);
    rdc(8'h85, 8'h03);
    rdc(8'h86, 8'h00);
    wr(8'h80, 8'h20, 1'b0);
    rdc(8'h80, 8'h00);
    wr(8'h86, 8'h80, 1'b1);
    rdc(8'h86, 8'h80);
    wr(8'h80, 8'h20, 1'b1);
    chk({7'h00, ana.sink}, 8'h01);
    stop_wait(1'b1);
    for (int i = 0; i < 64; i++) begin
      tbl[i] = (i == 63) ? 8'hff : 8'($urandom);
      wr(8'h90 + 8'(i), tbl[i], 1'b1);
    end
    for (int i = 0; i < 64; i++) rdc(8'h90 + 8'(i), tbl[i]);
    stop_wait(1'b1);
    for (int f = 1; f < 4; f++) begin
      wr(8'h85, 8'(f), 1'b1);
      chk({6'h00, ana.full_scale}, 8'(f));
    end
    c = 8'($urandom);
    wr(8'h80, 8'h80, 1'b1);
    adc(c);
    rdc(8'h87, c);
    chk(ana.dac_word, tbl[c[7:2]]);
    wr(8'h80, 8'h00, 1'b1);
    for (int k = 0; k < 3; k++) adc(c ^ 8'h80 ^ 8'(k));
    rdc(8'h87, c);
    adc(c ^ 8'h83);
    c = c ^ 8'h83;
    rdc(8'h87, c);
    chk(row_addr, 8'h90 + {2'b00, c[7:2]});
    chk(ana.dac_word, tbl[c[7:2]]);
    stop_wait(1'b1);
    r = 8'($urandom) & 8'h3f;
    t = 8'($urandom);
    wr(8'h81, r, 1'b1);
    wr(8'h83, t, 1'b1);
    stop_wait(1'b0);
    for (int j = 0; j < 4; j++) begin
      src = (j == 3) ? 8'h03 : 8'h13 + 8'(j) * 8'h10;
      wr(8'h85, src, 1'b1);
      chk(ana.dac_word, dac_exp(src, r, t, c));
      if (j == 0)
        chk(row_addr, 8'h90 + r);
    end
    wr(8'h80, 8'h40, 1'b1);
    chk({7'h00, ana.sink}, 8'h00);
    stop_wait(1'b1);
    wr(8'h81, r ^ 8'h01, 1'b1);
    stop_wait(1'b1);
    rdc(8'h82, 8'h00);
    wr(8'h84, 8'h00, 1'b1);
    rdc(8'h8c, 8'h00);
    wr(8'h87, 8'h00, 1'b1);
    rdc(8'h87, c);
    wr(8'h86, 8'h00, 1'b1);
    wr(8'h83, 8'h5a, 1'b0);
    rdc(8'h83, t);
    end_of_test();
  end
endmodule
`default_nettype wire
